// *** verilog/spse_serial_engine.sv ***
// serial port transmit/receive engine, synchronous mode 0 and async modes 1-3
// assumes software strobes are one-cycle pulses and mclk is the oscillator
`timescale 1ns/1ps
module spse_serial_engine import spse_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic clk6_mode,
    input wire logic smod,
    input wire logic baud_tick,
    input wire logic rx_enable,
    input wire logic multiprocessor_filter_bit,
    input wire logic transmit_ninth_bit,
    input wire logic buf_wr_en,
    input wire logic [7:0] buf_wr_data,
    input wire logic tx_flag_clr,
    input wire logic rx_flag_clr,
    input wire logic rxd_in,
    output logic [7:0] serial_data_buffer,
    output logic received_ninth_bit,
    output logic transmit_flag,
    output logic receive_flag,
    output logic rxd_out,
    output logic rxd_oe_b,
    output logic txd_out,
    output logic send_active,
    output logic receive_active
);
    // ********************************************************************
    // helpers
    // ********************************************************************
    // receive register runs left to right
    function automatic logic [7:0] to_buf(input logic [0:7] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[i];
        end
        return r;
    endfunction

    spse_tim_if tim ();
    spse_mode_t m;
    logic async_mode;
    logic fall_seen;
    logic bit_valid;
    logic bit_value;
    logic hunt;

    assign m = spse_mode_t'(mode);
    assign async_mode = m != SPSE_MODE0;

    spse_timing u_tim (
        .mclk(mclk),
        .rst_b(rst_b),
        .clk6_mode(clk6_mode),
        .smod(smod),
        .mode(mode),
        .baud_tick(baud_tick),
        .tim(tim)
    );

    spse_rx_sampler u_smp (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(tim.tick16),
        .rxd_in(rxd_in),
        .hunt(hunt),
        .fall_seen(fall_seen),
        .bit_valid(bit_valid),
        .bit_value(bit_value)
    );

    // ********************************************************************
    // transmit bit timing
    // ********************************************************************
    logic [3:0] txdiv_reg;
    logic roll_seen_reg;
    logic tx_roll;
    logic tx_evt;

    // [RULE_24] tick drives the divide-by-16
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txdiv_reg <= 4'h0;
        end else if (tim.tick16) begin
            txdiv_reg <= txdiv_reg + 4'h1;
        end
    end
    assign tx_roll = tim.tick16 && txdiv_reg == DIV16_LAST;

    // [RULE_10] act at S1P1 after rollover
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            roll_seen_reg <= 1'b0;
        end else if (tx_roll) begin
            roll_seen_reg <= 1'b1;
        end else if (tim.s1p1 || buf_wr_en) begin
            roll_seen_reg <= 1'b0;
        end
    end
    assign tx_evt = tim.s1p1 && roll_seen_reg;

    // ********************************************************************
    // transmit control
    // ********************************************************************
    spse_tx_st_t tx_st_reg;
    logic [8:0] tsr_reg;
    logic shifted_reg;
    logic aline_reg;
    logic tx_done;
    logic tx_fill;
    logic tx_at_end;

    // [RULE_19] first shift inserts the stop one
    assign tx_fill = m[1] && !shifted_reg;
    // [RULE_04] marker just left of the MSB
    assign tx_at_end = shifted_reg && tsr_reg[8:1] == TX_MARK_POS;
    assign tx_done = (tx_st_reg == TX_LAST && tim.s1p1) || (tx_st_reg == TX_DATA && async_mode && tx_evt && tx_at_end);

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            tx_st_reg <= TX_IDLE;
            tsr_reg <= 9'h1FF;
            shifted_reg <= 1'b0;
            send_active <= 1'b0;
            aline_reg <= 1'b1;
        end else if (buf_wr_en) begin
            // [RULE_02] marker one in mode 0/1
            // [RULE_19] ninth bit from software in modes 2/3
            tsr_reg <= {(m[1] ? transmit_ninth_bit : 1'b1), buf_wr_data};
            shifted_reg <= 1'b0;
            send_active <= 1'b0;
            aline_reg <= 1'b1;
            tx_st_reg <= TX_ARM;
        end else begin
            case (tx_st_reg)
                TX_IDLE: begin
                    aline_reg <= 1'b1;
                end
                TX_ARM: begin
                    // [RULE_02] send a machine cycle after the write
                    if (!async_mode && tim.s6p2) begin
                        tx_st_reg <= TX_SYNC;
                    end else if (async_mode && tx_evt) begin
                        // [RULE_11] start bit on the line
                        send_active <= 1'b1;
                        aline_reg <= 1'b0;
                        tx_st_reg <= TX_START;
                    end
                end
                TX_SYNC: begin
                    if (tim.s1p1) begin
                        send_active <= 1'b1;
                        tx_st_reg <= TX_DATA;
                    end
                end
                TX_START: begin
                    // [RULE_11] data path one bit time later
                    if (tx_evt) begin
                        aline_reg <= tsr_reg[0];
                        tx_st_reg <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (!async_mode && tim.s6p2) begin
                        // [RULE_03] shift right at S6P2
                        // [RULE_04] zeros enter from the left
                        tsr_reg <= {1'b0, tsr_reg[8:1]};
                        shifted_reg <= 1'b1;
                        if (tx_at_end) begin
                            tx_st_reg <= TX_LAST;
                        end
                    end else if (async_mode && tx_evt) begin
                        // [RULE_12] last shift, send off, flag
                        tsr_reg <= {tx_fill, tsr_reg[8:1]};
                        aline_reg <= tsr_reg[1];
                        shifted_reg <= 1'b1;
                        if (tx_at_end) begin
                            send_active <= 1'b0;
                            tx_st_reg <= TX_IDLE;
                        end
                    end
                end
                TX_LAST: begin
                    // [RULE_04] send off at S1P1
                    if (tim.s1p1) begin
                        send_active <= 1'b0;
                        tx_st_reg <= TX_IDLE;
                    end
                end
                default: begin
                    tx_st_reg <= TX_IDLE;
                end
            endcase
        end
    end

    // ********************************************************************
    // receive control
    // ********************************************************************
    spse_rx_st_t rx_st_reg;
    logic [0:8] rsr_reg;
    logic [0:8] rsr_shift;
    logic samp_reg;
    logic first_reg;
    logic rx_set;
    logic rx_accept;

    // [RULE_15] shift in the voted value
    assign rsr_shift = {rsr_reg[1:8], bit_value};
    // [RULE_16] mode 1: clear flag and filter off or stop one
    // [RULE_20] modes 2/3: clear flag and filter off or ninth one
    assign rx_accept = !receive_flag && (!multiprocessor_filter_bit || bit_value);
    assign hunt = rx_st_reg == RX_HUNT;

    // [RULE_06] pin sampled at S5P2
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            samp_reg <= 1'b1;
        end else if (tim.s5p2) begin
            samp_reg <= rxd_in;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rx_st_reg <= RX_IDLE;
            rsr_reg <= RXA_LOAD_VAL;
            first_reg <= 1'b0;
            receive_active <= 1'b0;
            rx_set <= 1'b0;
            serial_data_buffer <= 8'h00;
            received_ninth_bit <= 1'b0;
        end else begin
            rx_set <= 1'b0;
            case (rx_st_reg)
                RX_IDLE: begin
                    // [RULE_05] start on enable and clear flag
                    if (!async_mode && rx_enable && !receive_flag) begin
                        rx_st_reg <= RX0_ARM;
                    end else if (async_mode && rx_enable) begin
                        rx_st_reg <= RX_HUNT;
                    end
                end
                RX0_ARM: begin
                    if (tim.s1p1) begin
                        rx_st_reg <= RX0_LOAD;
                    end
                end
                RX0_LOAD: begin
                    // [RULE_05] load pattern and raise receive at the same S6P2
                    if (tim.s6p2) begin
                        rsr_reg[0:7] <= RX0_LOAD_VAL;
                        receive_active <= 1'b1;
                        rx_st_reg <= RX0_ACT;
                    end
                end
                RX0_ACT: begin
                    // [RULE_06] shift left at S6P2
                    if (tim.s6p2) begin
                        rsr_reg[0:7] <= {rsr_reg[1:7], samp_reg};
                        // [RULE_07] start zero at left: load buffer
                        if (!rsr_reg[0]) begin
                            serial_data_buffer <= to_buf({rsr_reg[1:7], samp_reg});
                            rx_st_reg <= RX0_LAST;
                        end
                    end
                end
                RX0_LAST: begin
                    // [RULE_07] receive off as flag sets
                    if (rx_set) begin
                        receive_active <= 1'b0;
                        rx_st_reg <= RX_IDLE;
                    end else if (tim.s1p1) begin
                        rx_set <= 1'b1;
                    end
                end
                RX_HUNT: begin
                    if (!rx_enable || !async_mode) begin
                        rx_st_reg <= RX_IDLE;
                    end else if (fall_seen) begin
                        // [RULE_13] load 1FF on the edge
                        rsr_reg <= RXA_LOAD_VAL;
                        first_reg <= 1'b1;
                        receive_active <= 1'b1;
                        rx_st_reg <= RX_BITS;
                    end
                end
                RX_BITS: begin
                    if (bit_valid) begin
                        first_reg <= 1'b0;
                        if (first_reg && bit_value) begin
                            // [RULE_15] false start rejected
                            receive_active <= 1'b0;
                            rx_st_reg <= RX_HUNT;
                        end else if (!rsr_reg[0]) begin
                            // [RULE_08] stop bit into ninth field
                            // [RULE_17] ninth data bit into ninth field
                            if (rx_accept) begin
                                serial_data_buffer <= to_buf(rsr_shift[0:7]);
                                received_ninth_bit <= rsr_shift[8];
                                rx_set <= 1'b1;
                            end
                            receive_active <= 1'b0;
                            // [RULE_20] 9-bit modes wait out the stop bit
                            rx_st_reg <= (m == SPSE_MODE1) ? RX_HUNT : RX_TAIL;
                        end else begin
                            rsr_reg <= rsr_shift;
                        end
                    end
                end
                RX_TAIL: begin
                    if (bit_valid) begin
                        rx_st_reg <= RX_HUNT;
                    end
                end
                default: begin
                    rx_st_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // ********************************************************************
    // flags
    // ********************************************************************
    // [RULE_21] hardware only sets; a set in the clear cycle wins
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            transmit_flag <= 1'b0;
        end else if (tx_done) begin
            transmit_flag <= 1'b1;
        end else if (tx_flag_clr) begin
            transmit_flag <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            receive_flag <= 1'b0;
        end else if (rx_set) begin
            receive_flag <= 1'b1;
        end else if (rx_flag_clr) begin
            receive_flag <= 1'b0;
        end
    end

    // ********************************************************************
    // pins
    // ********************************************************************
    logic sclk_reg;

    // [RULE_03] clock low S3..S5, high S6..S2
    // [RULE_06] edges at S3P1 and S6P1
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_reg <= 1'b1;
        end else if (!(send_active || receive_active) || async_mode) begin
            sclk_reg <= 1'b1;
        end else if (tim.s3p1) begin
            sclk_reg <= 1'b0;
        end else if (tim.s6p1) begin
            sclk_reg <= 1'b1;
        end
    end

    // [RULE_01] mode 0 clock on output pin, data on two-way pin
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            txd_out <= 1'b1;
            rxd_out <= 1'b1;
            rxd_oe_b <= 1'b1;
        end else begin
            txd_out <= async_mode ? aline_reg : sclk_reg;
            rxd_out <= tsr_reg[0];
            rxd_oe_b <= !(!async_mode && send_active);
        end
    end
endmodule

// *** verilog/spse_pkg.sv ***
// constants, modes and state codes of the serial port shift engine
// assumes one clock at the oscillator rate and software-facing plain ports
// ********************************************************************
// Behaviour
// [RULE_01] mode 0 moves eight bits LSB first on two-way data pin, drives shift clock
// [RULE_02] mode 0 write loads marker; send one machine cycle later
// [RULE_03] mode 0 transmit clock low S3-S5, high S6-S2; shift right at S6P2
// [RULE_04] mode 0 zero fill; last shift, send off, flag at cycle ten
// [RULE_05] mode 0 receive on enable, clear flag; load 11111110, then receive
// [RULE_06] mode 0 receive clock edges S3P1/S6P1; shift left at S6P2 with S5P2 sample
// [RULE_07] mode 0 start zero at left gives last shift, buffer load, flag cycle ten
// [RULE_08] mode 1 frame: start, eight data LSB first, stop; stop to ninth field
// [RULE_09] modes 1/3 rate from timer overflow into divide-by-16
// [RULE_10] async write only requests; frame starts S1P1 after next rollover
// [RULE_11] async send: start bit, data path one bit later, first shift one after that
// [RULE_12] mode 1 last shift, send off, transmit flag at rollover ten
// [RULE_13] async edge search at sixteen per bit; edge resets counter, loads 1FF
// [RULE_14] two of three votes at counter states seven, eight, nine
// [RULE_15] nonzero start vote aborts to edge search, else reception continues
// [RULE_16] mode 1 accept only with clear flag and filter off or stop bit one
// [RULE_17] modes 2/3 eleven-bit frame, software ninth bit, received ninth stored
// [RULE_18] mode 2 rate 1/32 or 1/64 (12-clock), 1/16 or 1/32 (6-clock); mode 3 timer
// [RULE_19] modes 2/3 ninth bit loaded; first shift inserts one; flag at rollover eleven
// [RULE_20] modes 2/3 accept on clear flag and filter off or ninth one; search one bit later
// [RULE_21] software clears both flags; hardware only sets them
// [RULE_22] software sets receive enable to allow reception
// [RULE_23] software keeps filter bit zero in mode 0
// [RULE_24] bit rate source is a one-cycle tick into the divide-by-16
// ********************************************************************
package spse_pkg;
    typedef enum logic [1:0] {
        SPSE_MODE0 = 2'b00,
        SPSE_MODE1 = 2'b01,
        SPSE_MODE2 = 2'b10,
        SPSE_MODE3 = 2'b11
    } spse_mode_t;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_ARM = 3'b001,
        TX_SYNC = 3'b010,
        TX_START = 3'b011,
        TX_DATA = 3'b100,
        TX_LAST = 3'b101
    } spse_tx_st_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX0_ARM = 3'b001,
        RX0_LOAD = 3'b010,
        RX0_ACT = 3'b011,
        RX0_LAST = 3'b100,
        RX_HUNT = 3'b101,
        RX_BITS = 3'b110,
        RX_TAIL = 3'b111
    } spse_rx_st_t;
    // phase index: state n phase p sits at 2*(n-1)+(p-1)
    localparam logic [3:0] PH_S1P1 = 4'h0;
    localparam logic [3:0] PH_S3P1 = 4'h4;
    localparam logic [3:0] PH_S5P1 = 4'h8;
    localparam logic [3:0] PH_S5P2 = 4'h9;
    localparam logic [3:0] PH_S6P1 = 4'hA;
    localparam logic [3:0] PH_S6P2 = 4'hB;
    localparam logic [3:0] PH_STEP12 = 4'h1;
    localparam logic [3:0] PH_STEP6 = 4'h2;
    // mode 2 tick dividers (terminal counts)
    localparam logic [1:0] M2_DIV12_SLOW = 2'h3;
    localparam logic [1:0] M2_DIV12_FAST = 2'h1;
    localparam logic [1:0] M2_DIV6_SLOW = 2'h1;
    localparam logic [1:0] M2_DIV6_FAST = 2'h0;
    localparam logic [3:0] DIV16_LAST = 4'hF;
    localparam logic [3:0] VOTE_FIRST = 4'h6;
    localparam logic [3:0] VOTE_MID = 4'h7;
    localparam logic [3:0] VOTE_LAST = 4'h8;
    localparam logic [7:0] RX0_LOAD_VAL = 8'hFE;
    localparam logic [8:0] RXA_LOAD_VAL = 9'h1FF;
    localparam logic [7:0] TX_MARK_POS = 8'h01;
endpackage

// *** verilog/spse_tim_if.sv ***
// machine-cycle strobes and the sixteen-times bit tick
// assumes one producer (timing) and one consumer (engine)
`timescale 1ns/1ps
interface spse_tim_if;
    logic s1p1;
    logic s3p1;
    logic s5p2;
    logic s6p1;
    logic s6p2;
    logic tick16;
    modport src (output s1p1, s3p1, s5p2, s6p1, s6p2, tick16);
    modport snk (input s1p1, s3p1, s5p2, s6p1, s6p2, tick16);
endinterface

// *** verilog/spse_timing.sv ***
// machine-cycle phase generator and bit tick select
// assumes mclk is the oscillator and baud_tick a one-cycle timer overflow
`timescale 1ns/1ps
module spse_timing import spse_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clk6_mode,
    input wire logic smod,
    input wire logic [1:0] mode,
    input wire logic baud_tick,
    spse_tim_if.src tim
);
    logic [3:0] pc_reg;
    logic [3:0] pc_step;
    logic [1:0] m2div_reg;
    logic [1:0] m2_term;
    logic m2_tick;

    // 6-clock mode walks only P1 slots, so P2 strobes fold onto them
    assign pc_step = clk6_mode ? PH_STEP6 : PH_STEP12;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pc_reg <= PH_S1P1;
        end else if (pc_reg + pc_step > PH_S6P2) begin
            pc_reg <= PH_S1P1;
        end else begin
            pc_reg <= pc_reg + pc_step;
        end
    end
    assign tim.s1p1 = pc_reg == PH_S1P1;
    assign tim.s3p1 = pc_reg == PH_S3P1;
    assign tim.s5p2 = (pc_reg == PH_S5P2) || (clk6_mode && pc_reg == PH_S5P1);
    assign tim.s6p1 = pc_reg == PH_S6P1;
    assign tim.s6p2 = (pc_reg == PH_S6P2) || (clk6_mode && pc_reg == PH_S6P1);

    // [RULE_18] mode 2 fixed rate
    assign m2_term = clk6_mode ? (smod ? M2_DIV6_FAST : M2_DIV6_SLOW) : (smod ? M2_DIV12_FAST : M2_DIV12_SLOW);
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            m2div_reg <= 2'h0;
        end else if (m2div_reg >= m2_term) begin
            m2div_reg <= 2'h0;
        end else begin
            m2div_reg <= m2div_reg + 2'h1;
        end
    end
    assign m2_tick = m2div_reg >= m2_term;
    // [RULE_09] timer overflow rate
    assign tim.tick16 = (mode == SPSE_MODE2) ? m2_tick : baud_tick;
endmodule

// *** verilog/spse_rx_sampler.sv ***
// sixteen-times receive sampler: edge finder and 2-of-3 voter
// assumes rxd_in synchronous to mclk and tick one cycle wide
`timescale 1ns/1ps
module spse_rx_sampler import spse_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic rxd_in,
    input wire logic hunt,
    output logic fall_seen,
    output logic bit_valid,
    output logic bit_value
);
    logic [3:0] cnt_reg;
    logic prev_reg;
    logic [1:0] smp_reg;

    // [RULE_13] edge search at sixteen times the rate
    assign fall_seen = hunt && tick && prev_reg && !rxd_in;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            prev_reg <= 1'b1;
        end else if (tick) begin
            prev_reg <= rxd_in;
        end
    end
    // [RULE_24] counter advances per tick
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= 4'h0;
        end else if (fall_seen) begin
            cnt_reg <= 4'h0;
        end else if (tick) begin
            cnt_reg <= cnt_reg + 4'h1;
        end
    end
    // [RULE_14] three samples, majority
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            smp_reg <= 2'b11;
        end else if (tick && cnt_reg == VOTE_FIRST) begin
            smp_reg[0] <= rxd_in;
        end else if (tick && cnt_reg == VOTE_MID) begin
            smp_reg[1] <= rxd_in;
        end
    end
    assign bit_valid = tick && cnt_reg == VOTE_LAST && !hunt;
    assign bit_value = (smp_reg[0] & smp_reg[1]) | (smp_reg[0] & rxd_in) | (smp_reg[1] & rxd_in);
endmodule

// *** verif/spse_serial_engine_assertions.sv ***
// port checks of the serial engine
// assumes the one mclk domain, rst_b active low
`timescale 1ns/1ps
module spse_serial_engine_assertions import spse_pkg::*; (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [1:0] mode,
    input wire logic clk6_mode,
    input wire logic multiprocessor_filter_bit,
    input wire logic tx_flag_clr,
    input wire logic transmit_flag,
    input wire logic receive_flag,
    input wire logic received_ninth_bit,
    input wire logic rxd_oe_b,
    input wire logic txd_out,
    input wire logic send_active,
    input wire logic receive_active
);
    // ****
    // checks
    // ****
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    a_oe_mode0: assert property (!rxd_oe_b |-> mode == SPSE_MODE0)
        else $error("pin driven");
    // 12-clock counts only
    a_clk_low: assert property ($fell(txd_out) && mode == SPSE_MODE0 && !clk6_mode |-> !txd_out [*6] ##1 txd_out)
        else $error("clock low");
    a_send_len: assert property ($rose(send_active) && mode == SPSE_MODE0 && !clk6_mode |-> ##95 send_active ##1 !send_active)
        else $error("send length");
    a_tflag_hold: assert property (transmit_flag && !tx_flag_clr |=> transmit_flag)
        else $error("flag dropped");
    a_send_flag: assert property ($fell(send_active) |-> transmit_flag)
        else $error("no flag");
    a_rx0_start: assert property ($rose(receive_active) && mode == SPSE_MODE0 |-> !receive_flag)
        else $error("rx with flag");
    a_rx0_end: assert property ($rose(receive_flag) && mode == SPSE_MODE0 |-> $fell(receive_active))
        else $error("rx end");
    a_filter_pass: assert property ($rose(receive_flag) && multiprocessor_filter_bit && mode != SPSE_MODE0 |-> received_ninth_bit)
        else $error("filter");
    a_txd_idle: assert property (mode != SPSE_MODE0 && !send_active && !$past(send_active) |-> txd_out)
        else $error("line not idle");
endmodule
bind spse_serial_engine spse_serial_engine_assertions chk_u (.*);

// *** verif/spse_partner.sv ***
// remote device: async frame sender, mode 0 shift register
// assumes rxd_oe_b low while the engine drives
`timescale 1ns/1ps
module spse_partner import spse_pkg::*; (
    input wire logic mclk,
    input wire logic sync_mode,
    input wire logic txd_out,
    input wire logic rxd_out,
    input wire logic rxd_oe_b,
    output logic rxd_in,
    output logic [7:0] m0_got
);
    logic [10:0] sh_reg = 11'h7FF;
    logic clk_d = 1'b1;
    // released pin carries the partner's sh_reg[0]
    assign rxd_in = rxd_oe_b ? sh_reg[0] : rxd_out;
    always @(posedge mclk) begin
        clk_d <= txd_out;
        if (sync_mode && txd_out && !clk_d) begin
            sh_reg <= {1'b1, sh_reg[10:1]};
            m0_got <= {rxd_in, m0_got[7:1]};
        end
    end
    task automatic load(input logic [10:0] f);
        #1 sh_reg = f;
    endtask
    task automatic send(input logic [10:0] f, input int per);
        load(f);
        repeat (11) begin
            repeat (per) @(posedge mclk);
            #1 sh_reg = {1'b1, sh_reg[10:1]};
        end
    endtask
endmodule

// *** verif/spse_serial_engine_tb.sv ***
// bench: async rows in a loop, then filter, glitch, mode 0
// assumes the partner model on the data pin
`timescale 1ns/1ps
module spse_serial_engine_tb import spse_pkg::*; ();
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0] mode = 2'h1;
    logic clk6_mode = 1'b0;
    logic smod = 1'b0;
    logic baud_tick = 1'b0;
    logic rx_enable = 1'b0;
    logic multiprocessor_filter_bit = 1'b0;
    logic transmit_ninth_bit = 1'b0;
    logic buf_wr_en = 1'b0;
    logic [7:0] buf_wr_data = 8'h00;
    logic tx_flag_clr = 1'b0;
    logic rx_flag_clr = 1'b0;
    logic rxd_in, received_ninth_bit, transmit_flag, receive_flag, rxd_out, rxd_oe_b, txd_out;
    logic send_active, receive_active;
    logic [7:0] serial_data_buffer, m0_got;
    logic [1:0] bc = 2'h0;
    logic [10:0] fr, ex;
    int bad_count = 0;
    int checks_done = 0;
    int per;
    // row: mode, 6-clock, doubler, ninth bit, data
    logic [12:0] rows [5] = '{13'h08A5, 13'h133C, 13'h1681, 13'h105A, 13'h19C3};
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
    spse_serial_engine dut_u (.*);
    spse_partner partner_u (.mclk, .sync_mode(mode == SPSE_MODE0), .txd_out, .rxd_out, .rxd_oe_b, .rxd_in, .m0_got);
    initial begin forever #5 mclk = ~mclk; end
    // overflow every 4 mclk: 64 mclk bits
    always @(posedge mclk) begin
        bc <= bc + 2'h1;
        baud_tick <= (bc == 2'h3);
    end
    task automatic strobe(input logic [2:0] w);
        {buf_wr_en, tx_flag_clr, rx_flag_clr} <= w;
        @(posedge mclk);
        {buf_wr_en, tx_flag_clr, rx_flag_clr} <= 3'h0;
    endtask
    task automatic cap;
        fr = 11'h7FF;
        wait (!txd_out);
        repeat (per / 2) @(posedge mclk);
        for (int i = 0; i < 11; i++) begin
            fr[i] = txd_out;
            repeat (per) @(posedge mclk);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin #500us; bad_count++; finish_test(); end
    initial begin
        repeat (4) @(posedge mclk);
        `CHK("reset", 14'h0C00, {transmit_flag, receive_flag, txd_out, rxd_oe_b, send_active, receive_active, serial_data_buffer})
        rst_b <= 1'b1;
        rx_enable <= 1'b1;
        foreach (rows[i]) begin
            {mode, clk6_mode, smod, transmit_ninth_bit, buf_wr_data} <= rows[i];
            per = rows[i][12:11] == 2'h2 ? 64 >> (int'(rows[i][10]) + rows[i][9]) : 64;
            ex = {1'b1, rows[i][12:11] == 2'h1 || rows[i][8], rows[i][7:0], 1'b0};
            @(posedge mclk);
            strobe(3'h4);
            cap();
            `CHK("tx frame", ex, fr)
            `CHK("tx flag", 1'b1, transmit_flag)
            strobe(3'h2);
            partner_u.send(ex, per);
            repeat (per) @(posedge mclk);
            `CHK("rx frame", {ex[9:1], 1'b1}, {received_ninth_bit, serial_data_buffer, receive_flag})
            strobe(3'h1);
        end
        // fast mode 2: short frames
        {mode, clk6_mode, smod, multiprocessor_filter_bit} <= 5'h17;
        @(posedge mclk);
        partner_u.send(11'h4AA, 16);
        `CHK("filtered", 1'b0, receive_flag)
        partner_u.send(11'h7FE, 2);
        partner_u.send(11'h6AA, 16);
        partner_u.send(11'h7F4, 16);
        `CHK("kept", 10'h2AB, {received_ninth_bit, serial_data_buffer, receive_flag})
        strobe(3'h1);
        {mode, clk6_mode, multiprocessor_filter_bit, rx_enable} <= 5'h00;
        buf_wr_data <= 8'h96;
        strobe(3'h4);
        wait (send_active);
        wait (!send_active);
        #1 `CHK("m0 tx", 9'h196, {transmit_flag, m0_got})
        partner_u.load(11'h74B);
        @(posedge mclk);
        rx_enable <= 1'b1;
        wait (receive_flag);
        #1 `CHK("m0 rx", 9'h04B, {receive_active, serial_data_buffer})
        finish_test();
    end
endmodule
